// ==== rtl/pisr_log_mem.sv ====
// Fault-log byte store with registered read data
`timescale 1ns/1ps
`default_nettype none
module pisr_log_mem #(
  parameter int DW = 8,
  parameter int AW = 8
) (
  // Clock
  input wire logic clk_sys_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  // Read port
  input wire logic rd_en_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);

  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rd_en_in) begin
      rd_data_out <= mem_r[rd_addr_in];
    end
  end

endmodule : pisr_log_mem
`default_nettype wire

// ==== rtl/pisr_pkg.sv ====
// Types shared by the identification and scratchpad register block
package pisr_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic page;
    logic [15:0] wdata;
  } pisr_cmd_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] rdata;
  } pisr_rsp_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } pisr_log_t;

endpackage : pisr_pkg

// ==== rtl/pisr_regs.svh ====
// Command codes, field positions, reset values and timing counts
//----------------------------------------------------------------
//----------------------------------------------------------------
`ifndef PISR_REGS_SVH
`define PISR_REGS_SVH

//----------------------------------------------------------------
// Command codes
//----------------------------------------------------------------
`define PISR_CMD_CAPABILITY 8'h19
`define PISR_CMD_REVISION 8'h98
`define PISR_CMD_TOOL_A 8'hB0
`define PISR_CMD_TOOL_B 8'hB1
`define PISR_CMD_OEM 8'hB2
`define PISR_CMD_SCRATCH_P 8'hB3
`define PISR_CMD_SCRATCH_G 8'hB4
`define PISR_CMD_INFO 8'hB6
`define PISR_CMD_MAKER_RSV 8'hBC
`define PISR_CMD_IDENTITY 8'hE7
`define PISR_CMD_LOT 8'hE8
`define PISR_CMD_IIN_RANGE 8'hD0
`define PISR_CMD_IIN_GAIN 8'hD1
`define PISR_CMD_IIN_TEMPCO 8'hD2

//----------------------------------------------------------------
// Fixed values and fields
//----------------------------------------------------------------
`define PISR_CAP_PEC_BIT 7
`define PISR_CAP_SCL_MSB 6
`define PISR_CAP_SCL_LSB 5
`define PISR_CAP_SCL_400K 2'h1
`define PISR_CAP_ALERT_BIT 4
`define PISR_REV_VALUE 8'h11
`define PISR_INFO_ECC_BIT 5
`define PISR_WORD_RST 16'h0000
`define PISR_LOG_LAST_VALID 8'hED
`define PISR_LOG_LAST 8'hFE
`define PISR_LOG_FILL 8'h00

//----------------------------------------------------------------
// Input current ranges, limits in microvolts
//----------------------------------------------------------------
`define PISR_RANGE_HIGH 2'h0
`define PISR_RANGE_MED 2'h1
`define PISR_RANGE_LOW 2'h2
`define PISR_LIM_HIGH_UV 18'sd100000
`define PISR_LIM_MED_UV 18'sd50000
`define PISR_LIM_LOW_UV 18'sd20000
`define PISR_PPM_SHIFT 20

//----------------------------------------------------------------
// Energy time base
//----------------------------------------------------------------
`define PISR_CLK_PERIOD_NS 10
`define PISR_TICK_NS 1000000
`define PISR_TICK_CYC (`PISR_TICK_NS / `PISR_CLK_PERIOD_NS)
`define PISR_UJ_PER_MJ 1000

`endif

// ==== rtl/pisr_top.sv ====
// Identification, scratchpad, fault-log read and input current block
`timescale 1ns/1ps
`default_nettype none
`include "pisr_regs.svh"
module pisr_top #(
  parameter logic [15:0] IDENTITY = 16'hA5C3, // arbitrary value
  parameter logic [7:0] LOT0 = 8'h00,
  parameter logic [7:0] LOT1 = 8'h00,
  parameter int TICK_CYC = `PISR_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Command port
  input wire pisr_pkg::pisr_cmd_t cmd_in,
  output pisr_pkg::pisr_rsp_t rsp_out,
  // EEPROM events
  input wire logic restore_in,
  input wire logic bulk_read_in,
  input wire logic ecc_clean_in,
  // Fault-log capture and block read
  input wire logic log_wr_in,
  input wire logic [7:0] log_waddr_in,
  input wire logic [7:0] log_wdata_in,
  input wire logic log_start_in,
  input wire logic log_rd_in,
  output pisr_pkg::pisr_log_t log_out,
  // Measurements
  input wire logic signed [17:0] sense_uv_in,
  input wire logic [15:0] vin_mv_in,
  input wire logic signed [7:0] temp_delta_in,
  output logic signed [23:0] iin_ma_out,
  output logic [15:0] vin_mv_out,
  output logic signed [39:0] pin_mw_out,
  output logic [47:0] ein_mj_out,
  output logic overrange_out
);

  //--------------------------------------------------------------
  // Register state
  //--------------------------------------------------------------
  logic [15:0] tool_a_r, oem_r, scratch_g_r, info_r, gain_r;
  logic [15:0] tool_b_r [0:1];
  logic [15:0] scratch_p_r [0:1];
  logic [15:0] maker_rsv_r [0:1];
  logic [1:0] range_r;
  logic signed [15:0] tempco_r;
  logic boot_r;
  logic [7:0] cap_value;
  logic wr, rd;

  assign cap_value = {1'b1, `PISR_CAP_SCL_400K, 1'b1, 4'h0};
  assign wr = cmd_in.valid & cmd_in.write;
  assign rd = cmd_in.valid & ~cmd_in.write;

  //--------------------------------------------------------------
  // Scratch words
  //--------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tool_a_r <= `PISR_WORD_RST;
      oem_r <= `PISR_WORD_RST;
      scratch_g_r <= `PISR_WORD_RST;
    end else if (wr) begin
      if (cmd_in.code == `PISR_CMD_TOOL_A) tool_a_r <= cmd_in.wdata;
      if (cmd_in.code == `PISR_CMD_OEM) oem_r <= cmd_in.wdata;
      if (cmd_in.code == `PISR_CMD_SCRATCH_G) scratch_g_r <= cmd_in.wdata;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_page
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          tool_b_r[p] <= `PISR_WORD_RST;
          scratch_p_r[p] <= `PISR_WORD_RST;
          maker_rsv_r[p] <= `PISR_WORD_RST;
        end else if (wr && cmd_in.page == 1'(p)) begin
          if (cmd_in.code == `PISR_CMD_TOOL_B) begin
            tool_b_r[p] <= cmd_in.wdata;
          end
          if (cmd_in.code == `PISR_CMD_SCRATCH_P) begin
            scratch_p_r[p] <= cmd_in.wdata;
          end
          if (cmd_in.code == `PISR_CMD_MAKER_RSV) begin
            maker_rsv_r[p] <= cmd_in.wdata;
          end
        end
      end
    end
  endgenerate

  //--------------------------------------------------------------
  // Information word
  //--------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      info_r <= `PISR_WORD_RST;
    end else if (boot_r || restore_in || bulk_read_in) begin
      info_r <= `PISR_WORD_RST;
      info_r[`PISR_INFO_ECC_BIT] <= ecc_clean_in;
    end
  end

  //--------------------------------------------------------------
  // Current sense settings
  //--------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      range_r <= `PISR_RANGE_HIGH;
      gain_r <= `PISR_WORD_RST;
      tempco_r <= `PISR_WORD_RST;
    end else if (wr) begin
      if (cmd_in.code == `PISR_CMD_IIN_RANGE) begin
        range_r <= cmd_in.wdata[1:0];
      end
      if (cmd_in.code == `PISR_CMD_IIN_GAIN) begin
        gain_r <= cmd_in.wdata;
      end
      if (cmd_in.code == `PISR_CMD_IIN_TEMPCO) begin
        tempco_r <= cmd_in.wdata;
      end
    end
  end

  //--------------------------------------------------------------
  // Command response
  //--------------------------------------------------------------
  logic [15:0] rdata;
  logic hit, ro;

  assign ro = cmd_in.code inside {`PISR_CMD_CAPABILITY, `PISR_CMD_REVISION,
    `PISR_CMD_IDENTITY, `PISR_CMD_LOT, `PISR_CMD_INFO};

  always_comb begin
    rdata = 16'h0000;
    hit = 1'b1;
    unique case (cmd_in.code)
      `PISR_CMD_CAPABILITY: rdata = {8'h00, cap_value};
      `PISR_CMD_REVISION: rdata = {8'h00, `PISR_REV_VALUE};
      `PISR_CMD_IDENTITY: rdata = IDENTITY;
      `PISR_CMD_LOT: rdata = {8'h00, cmd_in.page ? LOT1 : LOT0};
      `PISR_CMD_INFO: rdata = info_r;
      `PISR_CMD_TOOL_A: rdata = tool_a_r;
      `PISR_CMD_TOOL_B: rdata = tool_b_r[cmd_in.page];
      `PISR_CMD_OEM: rdata = oem_r;
      `PISR_CMD_SCRATCH_P: rdata = scratch_p_r[cmd_in.page];
      `PISR_CMD_SCRATCH_G: rdata = scratch_g_r;
      `PISR_CMD_MAKER_RSV: rdata = maker_rsv_r[cmd_in.page];
      `PISR_CMD_IIN_RANGE: rdata = {14'h0000, range_r};
      `PISR_CMD_IIN_GAIN: rdata = gain_r;
      `PISR_CMD_IIN_TEMPCO: rdata = tempco_r;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_out <= '0;
    end else begin
      rsp_out.valid <= cmd_in.valid;
      rsp_out.err <= cmd_in.valid & (~hit | (cmd_in.write & ro));
      rsp_out.rdata <= rd ? rdata : 16'h0000;
    end
  end

  //--------------------------------------------------------------
  // Fault-log block read
  //--------------------------------------------------------------
  typedef enum logic [1:0] {LOG_IDLE, LOG_RUN, LOG_DONE} log_state_t;
  log_state_t log_state_r;
  logic [7:0] log_ptr_r, mem_rdata;
  logic fill_r, last_r, log_valid_r, take;

  assign take = log_rd_in && log_state_r == LOG_RUN;

  pisr_log_mem #(.DW(8), .AW(8)) u_mem (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(log_wr_in),
    .wr_addr_in(log_waddr_in),
    .wr_data_in(log_wdata_in),
    .rd_en_in(take),
    .rd_addr_in(log_ptr_r),
    .rd_data_out(mem_rdata)
  );

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      log_state_r <= LOG_IDLE;
      log_ptr_r <= 8'h00;
    end else if (log_start_in) begin
      log_state_r <= LOG_RUN;
      log_ptr_r <= 8'h00;
    end else if (take) begin
      log_ptr_r <= log_ptr_r + 8'h01;
      if (log_ptr_r == `PISR_LOG_LAST) log_state_r <= LOG_DONE;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fill_r <= 1'b0;
      last_r <= 1'b0;
      log_valid_r <= 1'b0;
    end else begin
      fill_r <= log_ptr_r > `PISR_LOG_LAST_VALID;
      last_r <= log_ptr_r == `PISR_LOG_LAST;
      log_valid_r <= take;
    end
  end

  always_comb begin
    log_out.valid = log_valid_r;
    log_out.last = log_valid_r & last_r;
    log_out.data = fill_r ? `PISR_LOG_FILL : mem_rdata;
  end

  //--------------------------------------------------------------
  // Input current, power and energy
  //--------------------------------------------------------------
  logic signed [47:0] gain_adj, gain_eff, cur_ma;
  logic signed [17:0] lim, mag;
  logic [31:0] tick_cnt_r;
  logic [55:0] ein_uj_r;

  always_comb begin
    gain_adj = $signed({32'h0, gain_r}) * 48'(tempco_r) * 48'(temp_delta_in);
    gain_eff = $signed({32'h0, gain_r}) + (gain_adj >>> `PISR_PPM_SHIFT);
    cur_ma = (gain_eff > 48'sd0) ?
             $signed({{30{sense_uv_in[17]}}, sense_uv_in}) / gain_eff :
             48'sd0;
    mag = sense_uv_in < 18'sd0 ? -sense_uv_in : sense_uv_in;
    unique case (range_r)
      `PISR_RANGE_MED: lim = `PISR_LIM_MED_UV;
      `PISR_RANGE_LOW: lim = `PISR_LIM_LOW_UV;
      default: lim = `PISR_LIM_HIGH_UV;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      iin_ma_out <= 24'sh000000;
      vin_mv_out <= 16'h0000;
      pin_mw_out <= 40'sh0000000000;
      overrange_out <= 1'b0;
    end else begin
      iin_ma_out <= cur_ma[23:0];
      vin_mv_out <= vin_mv_in;
      pin_mw_out <= $signed({{16{iin_ma_out[23]}}, iin_ma_out}) *
        $signed({24'h000000, vin_mv_out}) / 40'sd1000;
      overrange_out <= mag > lim;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_r <= 32'h00000000;
      ein_uj_r <= 56'h0;
    end else if (tick_cnt_r == 32'(TICK_CYC - 1)) begin
      tick_cnt_r <= 32'h00000000;
      if (pin_mw_out >= 0) begin
        ein_uj_r <= ein_uj_r + 56'(pin_mw_out);
      end else if (ein_uj_r > 56'(-pin_mw_out)) begin
        ein_uj_r <= ein_uj_r - 56'(-pin_mw_out);
      end else begin
        ein_uj_r <= 56'h0;
      end
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
    end
  end

  assign ein_mj_out = 48'(ein_uj_r / `PISR_UJ_PER_MJ);

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rd(logic [7:0] c);
    cmd_in.valid && !cmd_in.write && cmd_in.code == c;
  endsequence

  property p_cap;
    s_rd(`PISR_CMD_CAPABILITY) |=> rsp_out.rdata == 16'h00B0;
  endproperty
  a_cap: assert property (p_cap) else $error("capability wrong");
  property p_rev;
    s_rd(`PISR_CMD_REVISION) |=> rsp_out.rdata == 16'h0011 && !rsp_out.err;
  endproperty
  a_rev: assert property (p_rev) else $error("revision wrong");
  property p_id;
    s_rd(`PISR_CMD_IDENTITY) |=> rsp_out.rdata == IDENTITY;
  endproperty
  a_id: assert property (p_id) else $error("identity wrong");
  property p_ro;
    wr && cmd_in.code == `PISR_CMD_INFO && !boot_r
      && !restore_in && !bulk_read_in |=> rsp_out.err && $stable(info_r);
  endproperty
  a_ro: assert property (p_ro) else $error("info written");
  property p_info;
    restore_in || bulk_read_in |=>
      info_r == {10'h000, $past(ecc_clean_in), 5'h00};
  endproperty
  a_info: assert property (p_info) else $error("info not refreshed");
  property p_fill;
    take && log_ptr_r > 8'hED |=> log_out.valid && log_out.data == 8'h00;
  endproperty
  a_fill: assert property (p_fill) else $error("filler not zero");
  property p_last;
    take && log_ptr_r == 8'hFE && !log_start_in
      |=> log_out.last ##1 log_state_r == LOG_DONE && !log_out.valid;
  endproperty
  a_last: assert property (p_last) else $error("bad log end");
  property p_scr;
    wr && cmd_in.code == `PISR_CMD_SCRATCH_G
      |=> scratch_g_r == $past(cmd_in.wdata);
  endproperty
  a_scr: assert property (p_scr) else $error("scratch lost");
  property p_ptr;
    take && !log_start_in |=> log_ptr_r == $past(log_ptr_r) + 8'h01;
  endproperty
  a_ptr: assert property (p_ptr) else $error("log not ascending");

endmodule : pisr_top
`default_nettype wire

// ==== verif/pisr_host_model.sv ====
// Host controller model driving the command port and fault-log reads
`timescale 1ns/1ps
`default_nettype none
module pisr_host_model (
  // Clock
  input wire logic clk_sys_in,
  // Device answers
  input wire pisr_pkg::pisr_rsp_t rsp_in,
  input wire pisr_pkg::pisr_log_t log_in,
  // Requests
  output pisr_pkg::pisr_cmd_t cmd_out,
  output logic log_start_out,
  output logic log_rd_out
);
  initial begin
    cmd_out = '0;
    log_start_out = 1'b0;
    log_rd_out = 1'b0;
  end

  // One command, answer awaited for a few cycles
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic pg, input logic [15:0] wd, output logic [15:0] rd,
    output logic err, output logic ok);
    pisr_pkg::pisr_cmd_t c;
    int n;
    c = '{valid: 1'b1, write: wr, code: code, page: pg, wdata: wd};
    @(posedge clk_sys_in);
    cmd_out <= c;
    @(posedge clk_sys_in);
    // Released fields show inverted garbage
    c = ~c;
    c.valid = 1'b0;
    cmd_out <= c;
    n = 0;
    #1;
    while (rsp_in.valid !== 1'b1 && n < 4) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    ok = (rsp_in.valid === 1'b1);
    rd = rsp_in.rdata;
    err = rsp_in.err;
  endtask : xfer

  task automatic log_begin();
    @(posedge clk_sys_in);
    log_start_out <= 1'b1;
    @(posedge clk_sys_in);
    log_start_out <= 1'b0;
  endtask : log_begin

  task automatic log_byte(output logic [7:0] d, output logic last,
    output logic ok);
    int n;
    @(posedge clk_sys_in);
    log_rd_out <= 1'b1;
    @(posedge clk_sys_in);
    log_rd_out <= 1'b0;
    n = 0;
    #1;
    while (log_in.valid !== 1'b1 && n < 4) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    ok = (log_in.valid === 1'b1);
    d = log_in.data;
    last = log_in.last;
  endtask : log_byte
endmodule : pisr_host_model
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the identification and scratchpad block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] ID_WORD = 16'h5A3C; // arbitrary value
  localparam logic [7:0] LOT_A = 8'h12;
  localparam logic [7:0] LOT_B = 8'h34;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  pisr_pkg::pisr_cmd_t cmd;
  pisr_pkg::pisr_rsp_t rsp;
  pisr_pkg::pisr_log_t lg;
  logic restore = 1'b0, bulk = 1'b0, ecc = 1'b1, log_wr = 1'b0;
  logic start, rdq, e, ok, last;
  logic [7:0] waddr = 8'h00, wdata = 8'h00, d;
  logic signed [17:0] sense = '0;
  logic [15:0] vin = 16'h0000, r;
  logic signed [7:0] tdelta = 8'h00;
  logic signed [23:0] iin;
  logic [15:0] vin_o;
  logic signed [39:0] pin;
  logic [47:0] ein;
  logic ovr;
  int bad_count = 0, n_compared = 0, cycles = 0;
  logic [7:0] ro_code [5] = '{8'h19, 8'h98, 8'hB6, 8'hE7, 8'hE8};
  logic [15:0] ro_val [5] = '{16'h00B0, 16'h0011, 16'h0020, ID_WORD,
    {8'h00, LOT_A}};
  logic [7:0] sc [6] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hBC};
  logic paged [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic signed [17:0] lim [3] = '{18'sd100000, 18'sd50000, 18'sd20000};

  always #5 clk_sys_in = ~clk_sys_in;

  pisr_top #(.IDENTITY(ID_WORD), .LOT0(LOT_A), .LOT1(LOT_B),
    .TICK_CYC(10)) dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .cmd_in(cmd), .rsp_out(rsp), .restore_in(restore),
    .bulk_read_in(bulk), .ecc_clean_in(ecc), .log_wr_in(log_wr),
    .log_waddr_in(waddr), .log_wdata_in(wdata), .log_start_in(start),
    .log_rd_in(rdq), .log_out(lg), .sense_uv_in(sense),
    .vin_mv_in(vin), .temp_delta_in(tdelta), .iin_ma_out(iin),
    .vin_mv_out(vin_o), .pin_mw_out(pin), .ein_mj_out(ein),
    .overrange_out(ovr));

  pisr_host_model host (.clk_sys_in(clk_sys_in), .rsp_in(rsp),
    .log_in(lg), .cmd_out(cmd), .log_start_out(start),
    .log_rd_out(rdq));

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd16(input logic [7:0] c, input logic p,
    input logic [15:0] exp);
    host.xfer(1'b0, c, p, 16'h0000, r, e, ok);
    chk({ok, e, r}, {2'b10, exp});
  endtask : rd16

  task automatic wr16(input logic [7:0] c, input logic p,
    input logic [15:0] wd, input logic experr);
    host.xfer(1'b1, c, p, wd, r, e, ok);
    chk({ok, e}, {1'b1, experr});
  endtask : wr16

  task automatic conclude();
    $display("Compared %0d values, %0d wrong", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  //--------------------------------------------------------------
  // Test sequence
  //--------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    for (int i = 0; i < 5; i++) rd16(ro_code[i], 1'b0, ro_val[i]);
    host.xfer(1'b0, 8'h19, 1'b1, 16'h0000, r, e, ok);
    chk(r, 16'h00B0);
    chk(r[7], 1'b1);
    chk(r[6:5], 2'b01);
    chk(r[4:0], 5'h10);
    rd16(8'h98, 1'b1, 16'h0011);
    rd16(8'hE7, 1'b1, ID_WORD);
    rd16(8'hE8, 1'b1, {8'h00, LOT_B});
    rd16(8'hB6, 1'b0, 16'h0020);
    for (int i = 0; i < 6; i++) begin
      rd16(sc[i], 1'b0, 16'h0000);
      rd16(sc[i], 1'b1, 16'h0000);
    end
    $display("Test reset values done");
    for (int i = 0; i < 5; i++) wr16(ro_code[i], 1'b0, 16'hFFFF, 1'b1);
    for (int i = 0; i < 5; i++) rd16(ro_code[i], 1'b0, ro_val[i]);
    host.xfer(1'b0, 8'h55, 1'b0, 16'h0000, r, e, ok);
    chk({ok, e}, 2'b11);
    $display("Test read-only writes done");
    for (int i = 0; i < 6; i++) begin
      wr16(sc[i], 1'b0, {sc[i], 8'h00}, 1'b0);
      wr16(sc[i], 1'b1, {sc[i], 8'h01}, 1'b0);
    end
    for (int i = 0; i < 6; i++) begin
      rd16(sc[i], 1'b0, {sc[i], 7'h00, !paged[i]});
      rd16(sc[i], 1'b1, {sc[i], 8'h01});
    end
    $display("Test scratch words done");
    @(posedge clk_sys_in) ecc <= 1'b0;
    rd16(8'hB6, 1'b0, 16'h0020);
    @(posedge clk_sys_in) restore <= 1'b1;
    @(posedge clk_sys_in) restore <= 1'b0;
    rd16(8'hB6, 1'b0, 16'h0000);
    @(posedge clk_sys_in) ecc <= 1'b1;
    @(posedge clk_sys_in) bulk <= 1'b1;
    @(posedge clk_sys_in) bulk <= 1'b0;
    rd16(8'hB6, 1'b0, 16'h0020);
    @(posedge clk_sys_in) ecc <= 1'b0;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rd16(8'hB6, 1'b0, 16'h0000);
    @(posedge clk_sys_in) ecc <= 1'b1;
    $display("Test info refresh done");
    for (int a = 0; a < 255; a++) begin
      @(posedge clk_sys_in);
      log_wr <= 1'b1;
      waddr <= a[7:0];
      wdata <= a[7:0] ^ 8'h5A;
    end
    @(posedge clk_sys_in) log_wr <= 1'b0;
    host.log_byte(d, last, ok);
    chk(ok, 1'b0);
    host.log_begin();
    for (int a = 0; a < 255; a++) begin
      host.log_byte(d, last, ok);
      chk({ok, last, d}, {1'b1, a == 254,
        (a <= 237) ? a[7:0] ^ 8'h5A : 8'h00});
    end
    host.log_byte(d, last, ok);
    chk(ok, 1'b0);
    $display("Test fault-log read done");
    wr16(8'hD0, 1'b0, 16'h0002, 1'b0);
    wr16(8'hD1, 1'b0, 16'd10, 1'b0);
    wr16(8'hD2, 1'b0, 16'h0000, 1'b0);
    @(posedge clk_sys_in) sense <= 18'sd10000;
    vin <= 16'd12000;
    tdelta <= 8'sd20;
    repeat (35) @(posedge clk_sys_in);
    #1;
    chk(iin, 48'd1000);
    chk(vin_o, 48'd12000);
    chk(pin, 48'd12000);
    chk(ein >= 48'd24, 48'h1);
    rd16(8'hD1, 1'b0, 16'd10);
    wr16(8'hD2, 1'b0, 16'd5243, 1'b0);
    rd16(8'hD2, 1'b0, 16'd5243);
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk(iin, 48'd909);
    chk(pin, 48'd10908);
    for (int k = 0; k < 3; k++) begin
      wr16(8'hD0, 1'b0, 16'(k), 1'b0);
      rd16(8'hD0, 1'b0, 16'(k));
      @(posedge clk_sys_in) sense <= lim[k] - 18'sd1;
      repeat (4) @(posedge clk_sys_in);
      #1;
      chk(ovr, 1'b0);
      @(posedge clk_sys_in) sense <= -(lim[k] + 18'sd1);
      repeat (4) @(posedge clk_sys_in);
      #1;
      chk(ovr, 1'b1);
    end
    $display("Test measurements done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
